/* wdt_swap_pkg.sv */
// constants for the watchdog restart and accumulator-memory swap execution unit
// assumes a 10-bit program word and a 4-bit data path inside one core clock domain
package wdt_swap_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W = 10;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned PTR_W  = 9;

  // ----------------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------------
  localparam logic [WORD_W-1:0] WATCHDOG_RESTART_CODE = 10'h2A0;
  localparam logic [WORD_W-1:0] WATCHDOG_DISABLE_CODE = 10'h29C;
  localparam logic [WORD_W-1:0] SWAP_CODE             = 10'h2C0;
  localparam logic [WORD_W-1:0] SWAP_MASK             = 10'h3F0;
  localparam int unsigned       IMM_LSB               = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [NIB_W-1:0] ACC_RESET = 4'h0;
  localparam logic [NIB_W-1:0] X_RESET   = 4'h0;
  localparam logic             WDF_RESET = 1'b0;

endpackage

/* op_decode_if.sv */
// carrier between the executing unit and its opcode decoder
// assumes both ends sit in the same clock domain; content is combinational
`timescale 1ns/100ps
`default_nettype none

interface op_decode_if;
  logic [wdt_swap_pkg::WORD_W-1:0] word;
  logic                            is_restart;
  logic                            is_disable;
  logic                            is_swap;
  logic [wdt_swap_pkg::NIB_W-1:0]  imm;

  modport dec (input word, output is_restart, is_disable, is_swap, imm);
  modport use_side (output word, input is_restart, is_disable, is_swap, imm);
endinterface

`default_nettype wire

/* op_decode.sv */
// opcode decoder for the watchdog restart, watchdog disable and swap words
// assumes the word presented is the one in the execute slot this cycle
`timescale 1ns/100ps
`default_nettype none

module op_decode
(
  op_decode_if.dec d
);

  // --------------------------------------------------------------------
  // match helper
  // --------------------------------------------------------------------
  function automatic logic hit(input logic [wdt_swap_pkg::WORD_W-1:0] w,
                               input logic [wdt_swap_pkg::WORD_W-1:0] code,
                               input logic [wdt_swap_pkg::WORD_W-1:0] mask);
    hit = ((w & mask) == (code & mask));
  endfunction

  assign d.is_restart = hit(d.word, wdt_swap_pkg::WATCHDOG_RESTART_CODE, 10'h3FF);
  assign d.is_disable = hit(d.word, wdt_swap_pkg::WATCHDOG_DISABLE_CODE, 10'h3FF);
  assign d.is_swap    = hit(d.word, wdt_swap_pkg::SWAP_CODE, wdt_swap_pkg::SWAP_MASK);
  assign d.imm        = d.word[wdt_swap_pkg::IMM_LSB +: wdt_swap_pkg::NIB_W];

endmodule // op_decode

`default_nettype wire

/* wdt_swap_exec.sv */
// execute unit for watchdog restart, watchdog disable and accumulator swap
// assumes mem_rdata holds the nibble at ram_pointer in the same cycle,
// and that the sequencer presents one instruction per instr_valid cycle
`timescale 1ns/100ps
`default_nettype none

module wdt_swap_exec
(
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             instr_valid,
  input  wire logic [wdt_swap_pkg::WORD_W-1:0]  instr,
  input  wire logic                             wdt_expire,
  input  wire logic [wdt_swap_pkg::PTR_W-1:0]   ram_pointer,
  input  wire logic [wdt_swap_pkg::NIB_W-1:0]   mem_rdata,
  input  wire logic                             acc_wr,
  input  wire logic [wdt_swap_pkg::NIB_W-1:0]   acc_wdata,
  input  wire logic                             x_wr,
  input  wire logic [wdt_swap_pkg::NIB_W-1:0]   x_wdata,
  output logic [wdt_swap_pkg::NIB_W-1:0]        acc,
  output logic [wdt_swap_pkg::NIB_W-1:0]        reg_x,
  output logic                                  watchdog_expiry_flag,
  output logic                                  watchdog_stopped,
  output logic                                  skip,
  output logic                                  skipped,
  output logic                                  done,
  output logic                                  mem_we,
  output logic [wdt_swap_pkg::PTR_W-1:0]        mem_addr,
  output logic [wdt_swap_pkg::NIB_W-1:0]        mem_wdata
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [wdt_swap_pkg::NIB_W-1:0] acc;
    logic [wdt_swap_pkg::NIB_W-1:0] x;
    logic                           wdf;
    logic                           stopped;
    logic                           prev_disable;
    logic                           skip_pend;
    logic                           skip;
    logic                           skipped;
    logic                           done;
    logic                           mem_we;
    logic [wdt_swap_pkg::PTR_W-1:0] mem_addr;
    logic [wdt_swap_pkg::NIB_W-1:0] mem_wdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    acc:          wdt_swap_pkg::ACC_RESET,
    x:            wdt_swap_pkg::X_RESET,
    wdf:          wdt_swap_pkg::WDF_RESET,
    stopped:      1'b0,
    prev_disable: 1'b0,
    skip_pend:    1'b0,
    skip:         1'b0,
    skipped:      1'b0,
    done:         1'b0,
    mem_we:       1'b0,
    mem_addr:     9'h000,
    mem_wdata:    4'h0
  };

  state_s st_q;
  state_s st_d;
  logic   exec;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  op_decode_if dif ();

  assign dif.word = instr;

  op_decode u_dec
  (
    .d (dif.dec)
  );

  // a word arriving while a skip is pending is discarded, not executed
  assign exec = instr_valid && !st_q.skip_pend;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    st_d         = st_q;
    st_d.skip    = 1'b0;
    st_d.skipped = 1'b0;
    st_d.done    = 1'b0;
    st_d.mem_we  = 1'b0;

    if (acc_wr)
    begin
      st_d.acc = acc_wdata;
    end
    if (x_wr)
    begin
      st_d.x = x_wdata;
    end

    if (instr_valid && st_q.skip_pend)
    begin
      // drop the word after a taken restart skip
      st_d.skip_pend    = 1'b0;
      st_d.skipped      = 1'b1;
      st_d.prev_disable = 1'b0;
    end
    else if (exec)
    begin
      st_d.done         = 1'b1;
      st_d.prev_disable = dif.is_disable;
      if (dif.is_restart)
      begin
        if (st_q.wdf)
        begin
          st_d.skip      = 1'b1;
          st_d.skip_pend = 1'b1;
          st_d.wdf       = 1'b0;
        end
        // flag at 0: nothing pending, next word runs
        if (st_q.prev_disable)
        begin
          st_d.stopped = 1'b1;
        end
      end
      if (dif.is_swap)
      begin
        st_d.acc       = mem_rdata;
        st_d.mem_we    = 1'b1;
        st_d.mem_addr  = ram_pointer;
        st_d.mem_wdata = st_q.acc;
        st_d.x         = st_q.x ^ dif.imm;
      end
    end

    // a new expiry wins over the clear in the same cycle
    if (wdt_expire && !st_q.stopped)
    begin
      st_d.wdf = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= STATE_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign acc                  = st_q.acc;
  assign reg_x                = st_q.x;
  assign watchdog_expiry_flag = st_q.wdf;
  assign watchdog_stopped     = st_q.stopped;
  assign skip                 = st_q.skip;
  assign skipped              = st_q.skipped;
  assign done                 = st_q.done;
  assign mem_we               = st_q.mem_we;
  assign mem_addr             = st_q.mem_addr;
  assign mem_wdata            = st_q.mem_wdata;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  // plain expression so it can join && and || in the properties below
  logic restart_flag_set;

  assign restart_flag_set = exec && dif.is_restart && st_q.wdf;

  a_skip_on_flag: assert property (
    restart_flag_set |=> skip && st_q.skip_pend)
    else $error("restart with flag set did not raise skip");

  a_skipped_word_dropped: assert property (
    st_q.skip_pend && instr_valid |=> skipped && !done && !mem_we && !st_q.skip_pend)
    else $error("word after taken skip was not discarded");

  a_flag_cleared: assert property (
    restart_flag_set && !wdt_expire |=> !watchdog_expiry_flag)
    else $error("flag not cleared after taken skip");

  a_no_skip_clear: assert property (
    exec && dif.is_restart && !st_q.wdf
      |=> (!skip && !st_q.skip_pend) and (instr_valid |=> done && !skipped))
    else $error("restart with flag clear caused a skip");

  a_stop_after_disable: assert property (
    exec && dif.is_disable ##1 exec && dif.is_restart |=> watchdog_stopped)
    else $error("watchdog not stopped after disable then restart");

  a_swap_exchange: assert property (
    exec && dif.is_swap
      |=> acc == $past(mem_rdata) && mem_wdata == $past(st_q.acc)
          && mem_we && mem_addr == $past(ram_pointer))
    else $error("swap did not exchange accumulator and memory");

  a_xor_index: assert property (
    exec && dif.is_swap |=> reg_x == ($past(st_q.x) ^ $past(dif.imm)))
    else $error("swap did not xor immediate into X");

  a_single_cycle: assert property (
    exec && (dif.is_restart || dif.is_swap) |=> done ##1 (!mem_we || !$past(dif.is_swap)))
    else $error("instruction did not finish in one cycle");

  a_stop_sticky: assert property (
    watchdog_stopped |=> watchdog_stopped)
    else $error("watchdog stop released without reset");

  c_skip_taken: cover property (restart_flag_set ##1 instr_valid ##1 skipped);
  c_stop_watchdog: cover property (exec && dif.is_disable ##1 exec && dif.is_restart);
  c_swap_back_to_back: cover property (exec && dif.is_swap ##1 exec && dif.is_swap);
  c_expire_on_clear: cover property (restart_flag_set && wdt_expire);

endmodule // wdt_swap_exec

`default_nettype wire

/* testbench.sv */
// self-checking bench for the watchdog restart and accumulator swap unit
// assumes registered outputs that settle within 1 ns after the clock edge
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       instr_valid = 1'b0;
  logic [9:0] instr = 10'h000;
  logic       wdt_expire = 1'b0;
  logic [8:0] ram_pointer = 9'h000;
  logic [3:0] mem_rdata = 4'h0;
  logic       acc_wr = 1'b0;
  logic [3:0] acc_wdata = 4'h0;
  logic       x_wr = 1'b0;
  logic [3:0] x_wdata = 4'h0;
  logic [3:0] acc, reg_x, mem_wdata;
  logic [8:0] mem_addr;
  logic       flag, stopped, skip, skipped, done, mem_we;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cycles = 0;

  wdt_swap_exec i_wdt_swap_exec (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .wdt_expire(wdt_expire), .ram_pointer(ram_pointer),
    .mem_rdata(mem_rdata), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .x_wr(x_wr),
    .x_wdata(x_wdata), .acc(acc), .reg_x(reg_x), .watchdog_expiry_flag(flag),
    .watchdog_stopped(stopped), .skip(skip), .skipped(skipped), .done(done),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

  always #4 clk = ~clk;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic drv(input logic v, input logic [9:0] w);
    @(posedge clk);
    instr_valid <= v;
    instr <= w;
  endtask

  task automatic expire_pulse;
    @(posedge clk);
    wdt_expire <= 1'b1;
    @(posedge clk);
    wdt_expire <= 1'b0;
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_swap;
    logic [3:0] a, x, m;
    logic [8:0] p;
    a = 4'h5;
    x = 4'hA;
    @(posedge clk);
    acc_wr <= 1'b1;
    acc_wdata <= a;
    x_wr <= 1'b1;
    x_wdata <= x;
    @(posedge clk);
    acc_wr <= 1'b0;
    x_wr <= 1'b0;
    for (int j = 0; j < 16; j++)
    begin
      m = 4'(j * 7 + 3);
      p = 9'(j * 33 + 1);
      drv(1'b1, wdt_swap_pkg::SWAP_CODE | {6'h00, 4'(j)});
      ram_pointer <= p;
      mem_rdata <= m;
      drv(1'b0, 10'h000);
      #1;
      chk_val({5'h00, acc}, {5'h00, m});
      chk_val({8'h00, mem_we}, 9'h001);
      chk_val(mem_addr, p);
      chk_val({5'h00, mem_wdata}, {5'h00, a});
      chk_val({5'h00, reg_x}, {5'h00, x ^ 4'(j)});
      chk_val({8'h00, done}, 9'h001);
      a = m;
      x = x ^ 4'(j);
    end
    @(posedge clk);
    #1;
    chk_val({8'h00, mem_we}, 9'h000);
    $display("test swap finished");
  endtask

  task automatic test_restart_clear;
    drv(1'b1, wdt_swap_pkg::WATCHDOG_RESTART_CODE);
    drv(1'b1, 10'h000);
    #1;
    chk_val({7'h00, done, skip}, 9'h002);
    chk_val({8'h00, stopped}, 9'h000);
    drv(1'b0, 10'h000);
    #1;
    chk_val({7'h00, skipped, done}, 9'h001);
    $display("test restart with flag clear finished");
  endtask

  task automatic test_restart_skip;
    logic [3:0] a;
    expire_pulse();
    chk_val({8'h00, flag}, 9'h001);
    a = acc;
    drv(1'b1, wdt_swap_pkg::WATCHDOG_RESTART_CODE);
    drv(1'b1, wdt_swap_pkg::SWAP_CODE | 10'h003);
    mem_rdata <= ~a;
    #1;
    chk_val({7'h00, skip, flag}, 9'h002);
    drv(1'b0, 10'h000);
    #1;
    chk_val({6'h00, skipped, done, mem_we}, 9'h004);
    chk_val({5'h00, acc}, {5'h00, a});
    $display("test restart with flag set finished");
  endtask

  task automatic test_disable;
    drv(1'b1, wdt_swap_pkg::WATCHDOG_DISABLE_CODE);
    drv(1'b1, wdt_swap_pkg::WATCHDOG_RESTART_CODE);
    drv(1'b0, 10'h000);
    #1;
    chk_val({7'h00, stopped, done}, 9'h003);
    expire_pulse();
    chk_val({8'h00, flag}, 9'h000);
    $display("test disable then restart finished");
  endtask

  // --------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 500)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_swap();
    test_restart_clear();
    test_restart_skip();
    test_disable();
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
